/* File: core/playback_output_timing.sv */
// Output-side timing of the playback module: observe-time clock, ticks and streams.
//
// Functional notes
// - One epoch pulse per second fixes the observe-time clock second tick.
// - Epoch pulse is used once when armed; later pulses are ignored.
// - Reference clock discontinuity needs a device reset, observe-time clock included.
// - Output clock rates of the reference divided by 2^n, n from 0 to 6, are supported.
// - Optional high reference rates pair with every lower output rate.
// - Reconstructed tick fires once per observe-time second, not wall-clock second.
// - Tick rate versus epoch pulse scales with the programmed speed factor.
// - Observe-time tick matches reconstructed tick; coincident when delay is zero.
// - Streams run at output clock divided by two to the power k.
// - Any reconstructed stream can map to any of 32 output positions.
// - One global valid level, high only while output data is synchronized.
// - Auxiliary serial output sends 115 kbaud, 8 data bits, one stop, no parity.
// - At most 2048 serial bytes per tick interval; tick source selectable.
// - Monitor copy of observe-time tick stretched to about ten milliseconds.
// - Speed change uses a programmable observe-time increment per reference cycle.
// - First sample keeps fixed timing to tick; then every 2^k clocks.
// - Only active streams need reconstructing, but routing stays fully free.
// - Output signals not in active use rest at logic one; streams and serial do, tick, strobe and monitor outputs idle low.
module playback_output_timing
	import playback_timing_pkg::*;
#(
	parameter int unsigned STREAMS        = NUM_STREAMS,
	parameter int unsigned MON_CYCLES     = MON_STRETCH_CYCLES,
	parameter int unsigned SERIAL_DIV     = BAUD_DIV,
	parameter int unsigned SERIAL_BURST   = BURST_MAX_BYTES
) (
	input  wire logic                            clk_sys_i,
	input  wire logic                            resetn_i,
	input  wire logic                            ref_clock_in_i,
	input  wire logic                            epoch_pulse_in_i,
	input  wire logic                            epoch_arm_i,
	input  wire logic [SECONDS_W-1:0]            epoch_seconds_i,
	input  wire logic [REF_HZ_W-1:0]             ref_freq_hz_i,
	input  wire logic [INCR_W-1:0]               observe_incr_i,
	input  wire logic [DIV_SEL_W-1:0]            out_div_log2_i,
	input  wire logic [DIV_SEL_W-1:0]            rate_k_i,
	input  wire logic [DELAY_W-1:0]              delay_offset_i,
	input  wire logic [STREAMS-1:0]              stream_data_i,
	input  wire logic [STREAMS*STREAM_IDX_W-1:0] stream_map_i,
	input  wire logic [STREAMS-1:0]              stream_enable_i,
	input  wire logic                            data_valid_i,
	input  wire logic                            serial_tick_sel_i,
	input  wire logic                            serial_valid_i,
	input  wire logic [UART_DATA_BITS-1:0]       serial_byte_i,
	output logic                                 serial_ready_o,
	output logic                                 recon_clock_o,
	output logic                                 recon_tick_out_o,
	output logic                                 observe_time_tick_out_o,
	output logic [STREAMS-1:0]                   recon_stream_out_o,
	output logic                                 sample_strobe_o,
	output logic                                 output_valid_o,
	output logic                                 aux_serial_out_o,
	output logic                                 observe_tick_monitor_o,
	output logic [SECONDS_W-1:0]                 observe_seconds_o,
	output logic                                 epoch_armed_o,
	output logic                                 ref_fault_o
);

	initial begin
		if (STREAMS != (1 << STREAM_IDX_W) || MON_CYCLES < 1) begin
			$error("playback_output_timing: STREAMS must equal 32, MON_CYCLES at least 1");
		end
	end

	localparam int unsigned DIVCNT_W = MAX_DIV_LOG2;
	localparam int unsigned SAMP_W   = MAX_RATE_K + 1;
	localparam int unsigned TO_W     = $clog2(REF_TIMEOUT_CYCLES + 1);

	// Selects one source bit by index; used by every crossbar output.
	function automatic logic pick_stream(input logic [STREAMS-1:0] src,
		input logic [STREAM_IDX_W-1:0] idx);
		pick_stream = src[idx];
	endfunction

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic ref_s1_r;
	logic ref_s2_r;
	logic ref_d_r;
	logic epo_s1_r;
	logic epo_s2_r;
	logic epo_d_r;
	logic ref_rise;
	logic epoch_rise;

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ref_s1_r <= 1'b0;
			ref_s2_r <= 1'b0;
			ref_d_r  <= 1'b0;
			epo_s1_r <= 1'b0;
			epo_s2_r <= 1'b0;
			epo_d_r  <= 1'b0;
		end else begin
			ref_s1_r <= ref_clock_in_i;
			ref_s2_r <= ref_s1_r;
			ref_d_r  <= ref_s2_r;
			epo_s1_r <= epoch_pulse_in_i;
			epo_s2_r <= epo_s1_r;
			// The epoch level is compared from one reference rise to the next, because the pin
			// changes away from the reference rising edge.
			epo_d_r  <= (ref_s2_r && !ref_d_r) ? epo_s2_r : epo_d_r;
		end
	end

	assign ref_rise   = ref_s2_r && !ref_d_r;
	assign epoch_rise = epo_s2_r && !epo_d_r && ref_rise;

	// ---------------------------------------------------------------
	// Reference clock watchdog
	// ---------------------------------------------------------------
	logic [TO_W-1:0] ref_to_r;

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ref_to_r    <= '0;
			ref_fault_o <= 1'b0;
		end else begin
			ref_to_r <= ref_rise ? '0 : ref_to_r + TO_W'(!ref_fault_o);
			// A stalled reference latches the fault until the next reset.
			if (ref_to_r == TO_W'(REF_TIMEOUT_CYCLES)) begin
				ref_fault_o <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// Observe-time clock
	// ---------------------------------------------------------------
	logic [ACC_W-1:0] acc_r;
	logic [ACC_W-1:0] acc_sum;
	logic [ACC_W-1:0] acc_limit;
	logic             synced_r;
	logic             epoch_load;
	logic             sec_tick;

	assign acc_sum    = acc_r + ACC_W'(observe_incr_i);
	assign acc_limit  = {ref_freq_hz_i, FRAC_BITS'(0)};
	assign epoch_load = epoch_rise && epoch_armed_o && !ref_fault_o;
	assign sec_tick   = epoch_load
		|| (synced_r && ref_rise && acc_sum >= acc_limit);

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			epoch_armed_o <= 1'b0;
		end else if (epoch_arm_i) begin
			epoch_armed_o <= 1'b1;
		end else if (epoch_load) begin
			epoch_armed_o <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			acc_r             <= '0;
			observe_seconds_o <= '0;
			synced_r          <= 1'b0;
		end else if (ref_fault_o) begin
			synced_r <= 1'b0;
		end else if (epoch_load) begin
			acc_r             <= '0;
			observe_seconds_o <= epoch_seconds_i;
			synced_r          <= 1'b1;
		end else if (synced_r && ref_rise) begin
			if (acc_sum >= acc_limit) begin
				acc_r             <= acc_sum - acc_limit;
				observe_seconds_o <= observe_seconds_o + SECONDS_W'(1);
			end else begin
				acc_r <= acc_sum;
			end
		end
	end

	// ---------------------------------------------------------------
	// Output clock divider
	// ---------------------------------------------------------------
	logic [DIVCNT_W-1:0]  divcnt_r;
	logic [DIVCNT_W-1:0]  divcnt_nxt;
	logic [DIV_SEL_W-1:0] div_sel;
	logic                 rclk_nxt;
	logic                 out_rise;

	assign div_sel = (out_div_log2_i > DIV_SEL_W'(MAX_DIV_LOG2))
		? DIV_SEL_W'(MAX_DIV_LOG2) : out_div_log2_i;

	always_comb begin
		divcnt_nxt = divcnt_r;
		if (epoch_load) begin
			divcnt_nxt = '0;
		end else if (ref_rise) begin
			divcnt_nxt = divcnt_r + DIVCNT_W'(1);
		end
		// Output clock is the reference divided by 2^div_sel.
		rclk_nxt = (div_sel == '0) ? ref_s2_r : !divcnt_nxt[div_sel - DIV_SEL_W'(1)];
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			divcnt_r      <= '0;
			recon_clock_o <= 1'b0;
		end else begin
			divcnt_r      <= divcnt_nxt;
			recon_clock_o <= rclk_nxt;
		end
	end

	assign out_rise = rclk_nxt && !recon_clock_o;

	// ---------------------------------------------------------------
	// Reconstructed and observe-time ticks
	// ---------------------------------------------------------------
	logic                  tick_pend_r;
	logic                  obs_pend_r;
	logic [DELAY_W-1:0]    obs_cnt_r;
	logic [TICK_CNT_W-1:0] rt_len_r;
	logic [TICK_CNT_W-1:0] ot_len_r;
	logic                  tick_start;
	logic                  obs_start;

	assign tick_start = out_rise && tick_pend_r;
	assign obs_start  = (tick_start && delay_offset_i == '0)
		|| (out_rise && obs_pend_r && obs_cnt_r == DELAY_W'(1));

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tick_pend_r <= 1'b0;
			obs_pend_r  <= 1'b0;
			obs_cnt_r   <= '0;
		end else begin
			if (sec_tick) begin
				tick_pend_r <= 1'b1;
			end else if (tick_start) begin
				tick_pend_r <= 1'b0;
			end
			if (tick_start && delay_offset_i != '0) begin
				obs_pend_r <= 1'b1;
				obs_cnt_r  <= delay_offset_i;
			end else if (out_rise && obs_pend_r) begin
				obs_cnt_r  <= obs_cnt_r - DELAY_W'(1);
				obs_pend_r <= (obs_cnt_r != DELAY_W'(1));
			end
		end
	end

	// Each tick ends at the next output clock rise or at the length cap.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			recon_tick_out_o        <= 1'b0;
			observe_time_tick_out_o <= 1'b0;
			rt_len_r                <= '0;
			ot_len_r                <= '0;
		end else begin
			rt_len_r <= recon_tick_out_o ? rt_len_r + TICK_CNT_W'(1) : '0;
			ot_len_r <= observe_time_tick_out_o ? ot_len_r + TICK_CNT_W'(1) : '0;
			if (tick_start) begin
				recon_tick_out_o <= 1'b1;
			end else if (out_rise || rt_len_r == TICK_CNT_W'(TICK_MAX_CYCLES - 1)) begin
				recon_tick_out_o <= 1'b0;
			end
			if (obs_start) begin
				observe_time_tick_out_o <= 1'b1;
			end else if (out_rise || ot_len_r == TICK_CNT_W'(TICK_MAX_CYCLES - 1)) begin
				observe_time_tick_out_o <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// Stream sampling and crossbar
	// ---------------------------------------------------------------
	logic [SAMP_W-1:0]    samp_r;
	logic [SAMP_W-1:0]    samp_nxt;
	logic [SAMP_W-1:0]    samp_mask;
	logic [DIV_SEL_W-1:0] k_sel;
	logic [STREAMS-1:0]   xbar;

	assign k_sel     = (rate_k_i > DIV_SEL_W'(MAX_RATE_K)) ? DIV_SEL_W'(MAX_RATE_K) : rate_k_i;
	assign samp_mask = (SAMP_W'(1) << k_sel) - SAMP_W'(1);
	// The first sample lands on the tick's own clock edge.
	assign samp_nxt  = tick_start ? '0 : ((samp_r + SAMP_W'(1)) & samp_mask);

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			samp_r          <= '0;
			sample_strobe_o <= 1'b0;
		end else begin
			sample_strobe_o <= out_rise && samp_nxt == '0;
			if (out_rise) begin
				samp_r <= samp_nxt;
			end
		end
	end

	generate
		for (genvar n = 0; n < STREAMS; n++) begin : g_xbar
			assign xbar[n] = pick_stream(stream_data_i,
				stream_map_i[n*STREAM_IDX_W +: STREAM_IDX_W]);
		end
	endgenerate

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			recon_stream_out_o <= '1;
		end else if (!output_valid_o) begin
			recon_stream_out_o <= '1;
		end else if (out_rise && samp_nxt == '0) begin
			recon_stream_out_o <= xbar | ~stream_enable_i;
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			output_valid_o <= 1'b0;
		end else begin
			output_valid_o <= synced_r && data_valid_i && !ref_fault_o;
		end
	end

	// ---------------------------------------------------------------
	// Auxiliary serial channel and monitor
	// ---------------------------------------------------------------
	logic burst_restart;

	assign burst_restart = serial_tick_sel_i ? obs_start : tick_start;

	serial_tx #(
		.DIV       (SERIAL_DIV),
		.BURST_MAX (SERIAL_BURST)
	) u_serial (
		.clk_sys_i       (clk_sys_i),
		.resetn_i        (resetn_i),
		.burst_restart_i (burst_restart),
		.byte_valid_i    (serial_valid_i),
		.byte_i          (serial_byte_i),
		.byte_ready_o    (serial_ready_o),
		.serial_o        (aux_serial_out_o)
	);

	tick_stretch #(
		.LEN (MON_CYCLES)
	) u_monitor (
		.clk_sys_i (clk_sys_i),
		.resetn_i  (resetn_i),
		.pulse_i   (obs_start),
		.stretch_o (observe_tick_monitor_o)
	);

endmodule

/* File: core/playback_timing_pkg.sv */
// Shared constants and types for the playback output timing block.
package playback_timing_pkg;

	// ---------------------------------------------------------------
	// System clock
	// ---------------------------------------------------------------
	localparam int unsigned CLK_HZ        = 250_000_000;
	localparam int unsigned CLK_PERIOD_NS = 4;

	// ---------------------------------------------------------------
	// Tick timing
	// ---------------------------------------------------------------
	localparam int unsigned TICK_MAX_NS        = 500;
	localparam int unsigned TICK_MAX_CYCLES    = TICK_MAX_NS / CLK_PERIOD_NS;
	localparam int unsigned MON_STRETCH_NS     = 10_000_000;
	localparam int unsigned MON_STRETCH_CYCLES = MON_STRETCH_NS / CLK_PERIOD_NS;
	localparam int unsigned REF_TIMEOUT_NS     = 1_000;
	localparam int unsigned REF_TIMEOUT_CYCLES = REF_TIMEOUT_NS / CLK_PERIOD_NS;
	localparam int unsigned TICK_CNT_W         = 8;

	// ---------------------------------------------------------------
	// Auxiliary serial channel
	// ---------------------------------------------------------------
	localparam int unsigned BAUD_RATE       = 115_200;
	localparam int unsigned BAUD_DIV        = CLK_HZ / BAUD_RATE;
	localparam int unsigned UART_DATA_BITS  = 8;
	localparam int unsigned BURST_MAX_BYTES = 2048;

	// ---------------------------------------------------------------
	// Observe-time clock and stream layout
	// ---------------------------------------------------------------
	localparam int unsigned FRAC_BITS     = 16;
	localparam int unsigned INCR_W        = 24;
	localparam int unsigned REF_HZ_W      = 28;
	localparam int unsigned ACC_W         = REF_HZ_W + FRAC_BITS;
	localparam int unsigned SECONDS_W     = 32;
	localparam int unsigned DIV_SEL_W     = 3;
	localparam int unsigned MAX_DIV_LOG2  = 6;
	localparam int unsigned MAX_RATE_K    = 6;
	localparam int unsigned DELAY_W       = 16;
	localparam int unsigned NUM_STREAMS   = 32;
	localparam int unsigned STREAM_IDX_W  = 5;

	typedef enum logic [1:0] {
		TX_IDLE,
		TX_START,
		TX_DATA,
		TX_STOP
	} tx_state_e;

endpackage

/* File: core/tick_stretch.sv */
// Pulse stretcher that widens a short tick for monitor viewing.
module tick_stretch
	import playback_timing_pkg::*;
#(
	parameter int unsigned LEN = MON_STRETCH_CYCLES
) (
	input  wire logic clk_sys_i,
	input  wire logic resetn_i,
	input  wire logic pulse_i,
	output logic      stretch_o
);

	initial begin
		if (LEN < 1) begin
			$error("tick_stretch: LEN must be at least one");
		end
	end

	localparam int unsigned CNT_W = $clog2(LEN + 1);

	logic [CNT_W-1:0] cnt_r;

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_r <= '0;
		end else if (pulse_i) begin
			cnt_r <= CNT_W'(LEN);
		end else if (cnt_r != '0) begin
			cnt_r <= cnt_r - CNT_W'(1);
		end
	end

	assign stretch_o = (cnt_r != '0);

endmodule

/* File: core/serial_tx.sv */
// Asynchronous 8N1 transmitter with a per-tick byte budget.
module serial_tx
	import playback_timing_pkg::*;
#(
	parameter int unsigned DIV       = BAUD_DIV,
	parameter int unsigned BURST_MAX = BURST_MAX_BYTES
) (
	input  wire logic                      clk_sys_i,
	input  wire logic                      resetn_i,
	input  wire logic                      burst_restart_i,
	input  wire logic                      byte_valid_i,
	input  wire logic [UART_DATA_BITS-1:0] byte_i,
	output logic                           byte_ready_o,
	output logic                           serial_o
);

	initial begin
		if (DIV < 2 || BURST_MAX < 1) begin
			$error("serial_tx: DIV must be at least 2 and BURST_MAX at least 1");
		end
	end

	localparam int unsigned DIV_W   = $clog2(DIV);
	localparam int unsigned BURST_W = $clog2(BURST_MAX + 1);
	localparam int unsigned BIT_W   = $clog2(UART_DATA_BITS);

	tx_state_e                 state_r;
	logic [DIV_W-1:0]          baud_r;
	logic [BIT_W-1:0]          bit_r;
	logic [UART_DATA_BITS-1:0] shift_r;
	logic [BURST_W-1:0]        sent_r;
	logic                      baud_end;
	logic                      take;

	assign baud_end     = (baud_r == DIV_W'(DIV - 1));
	// A byte is refused once the budget for this tick interval is spent.
	assign byte_ready_o = (state_r == TX_IDLE) && (sent_r != BURST_W'(BURST_MAX));
	assign take         = byte_valid_i && byte_ready_o;

	// ---------------------------------------------------------------
	// Bit framing
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_r  <= TX_IDLE;
			baud_r   <= '0;
			bit_r    <= '0;
			shift_r  <= '0;
			serial_o <= 1'b1;
		end else begin
			baud_r <= (state_r == TX_IDLE || baud_end) ? '0 : baud_r + DIV_W'(1);
			case (state_r)
				TX_IDLE: begin
					serial_o <= 1'b1;
					if (take) begin
						shift_r  <= byte_i;
						serial_o <= 1'b0;
						state_r  <= TX_START;
					end
				end
				TX_START: begin
					if (baud_end) begin
						serial_o <= shift_r[0];
						shift_r  <= shift_r >> 1;
						bit_r    <= '0;
						state_r  <= TX_DATA;
					end
				end
				TX_DATA: begin
					if (baud_end) begin
						if (bit_r == BIT_W'(UART_DATA_BITS - 1)) begin
							serial_o <= 1'b1;
							state_r  <= TX_STOP;
						end else begin
							serial_o <= shift_r[0];
							shift_r  <= shift_r >> 1;
							bit_r    <= bit_r + BIT_W'(1);
						end
					end
				end
				TX_STOP: begin
					if (baud_end) begin
						state_r <= TX_IDLE;
					end
				end
				default: begin
					state_r <= TX_IDLE;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Byte budget between ticks
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sent_r <= '0;
		end else if (burst_restart_i) begin
			sent_r <= take ? BURST_W'(1) : '0;
		end else if (take) begin
			sent_r <= sent_r + BURST_W'(1);
		end
	end

endmodule

/* File: tb/playback_output_timing_properties.sv */
// Port-level checker for tick, serial, valid and monitor timing of the playback block.
module playback_output_timing_properties
	import playback_timing_pkg::*;
#(
	parameter int unsigned MON_CYCLES = 20
) (
	input wire logic                 clk_sys_i,
	input wire logic                 resetn_i,
	input wire logic [SECONDS_W-1:0] epoch_seconds_i,
	input wire logic [DELAY_W-1:0]   delay_offset_i,
	input wire logic                 data_valid_i,
	input wire logic                 serial_valid_i,
	input wire logic                 serial_ready_o,
	input wire logic                 recon_tick_out_o,
	input wire logic                 observe_time_tick_out_o,
	input wire logic                 sample_strobe_o,
	input wire logic                 output_valid_o,
	input wire logic                 aux_serial_out_o,
	input wire logic                 observe_tick_monitor_o,
	input wire logic [SECONDS_W-1:0] observe_seconds_o,
	input wire logic                 epoch_armed_o,
	input wire logic                 ref_fault_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);

	int unsigned mon_cnt_r;

	// Counts how long the monitor copy has been high.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			mon_cnt_r <= 0;
		end else if (observe_tick_monitor_o) begin
			mon_cnt_r <= mon_cnt_r + 1;
		end else begin
			mon_cnt_r <= 0;
		end
	end

	property p_tick_max;
		$rose(recon_tick_out_o) |-> ##[1:125] !recon_tick_out_o;
	endproperty
	a_tick_max: assert property (p_tick_max) else $error("recon tick too long");
	property p_tick_min;
		$rose(recon_tick_out_o) |=> recon_tick_out_o;
	endproperty
	a_tick_min: assert property (p_tick_min) else $error("recon tick too short");
	property p_obs_max;
		$rose(observe_time_tick_out_o) |-> ##[1:125] !observe_time_tick_out_o;
	endproperty
	a_obs_max: assert property (p_obs_max) else $error("observe tick too long");
	property p_coinc;
		delay_offset_i == '0 |-> observe_time_tick_out_o == recon_tick_out_o;
	endproperty
	a_coinc: assert property (p_coinc) else $error("ticks not coincident");
	property p_strobe;
		$rose(recon_tick_out_o) |-> sample_strobe_o;
	endproperty
	a_strobe: assert property (p_strobe) else $error("first sample not tied to tick");
	property p_valid;
		!data_valid_i || ref_fault_o |=> !output_valid_o;
	endproperty
	a_valid: assert property (p_valid) else $error("valid high without cause");
	property p_fault;
		ref_fault_o |=> ref_fault_o;
	endproperty
	a_fault: assert property (p_fault) else $error("fault cleared without reset");
	property p_load;
		$fell(epoch_armed_o) |-> observe_seconds_o == epoch_seconds_i;
	endproperty
	a_load: assert property (p_load) else $error("epoch not loaded");
	property p_start;
		serial_valid_i && serial_ready_o |=> !aux_serial_out_o && !serial_ready_o;
	endproperty
	a_start: assert property (p_start) else $error("no start bit");
	property p_busy;
		!aux_serial_out_o |-> !serial_ready_o;
	endproperty
	a_busy: assert property (p_busy) else $error("ready while sending");
	property p_mon;
		$fell(observe_tick_monitor_o) |-> mon_cnt_r == MON_CYCLES;
	endproperty
	a_mon: assert property (p_mon) else $error("monitor stretch wrong");

	c_load: cover property ($fell(epoch_armed_o));
	c_tick: cover property ($rose(recon_tick_out_o));
	c_byte: cover property (serial_valid_i && serial_ready_o);
endmodule

bind playback_output_timing playback_output_timing_properties #(.MON_CYCLES(MON_CYCLES)) u_chk (
	.clk_sys_i, .resetn_i, .epoch_seconds_i, .delay_offset_i, .data_valid_i,
	.serial_valid_i, .serial_ready_o, .recon_tick_out_o, .observe_time_tick_out_o,
	.sample_strobe_o, .output_valid_o, .aux_serial_out_o, .observe_tick_monitor_o,
	.observe_seconds_o, .epoch_armed_o, .ref_fault_o);

/* File: tb/proc_sys_model.sv */
// Processing-system model: reference clock and once-per-second epoch pulse.
module proc_sys_model #(
	parameter int unsigned HALF_NS = 16,
	parameter int unsigned PER_SEC = 8
) (
	input  wire logic run_i,
	output logic      ref_clock_o,
	output logic      epoch_pulse_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned cnt = 0;
	// The pulse changes on the falling edge so it is stable around each rising edge.
	initial begin
		ref_clock_o = 1'b0;
		epoch_pulse_o = 1'b0;
		#3;
		forever begin
			#HALF_NS;
			ref_clock_o = run_i ? ~ref_clock_o : 1'b0;
			if (run_i && !ref_clock_o) begin
				epoch_pulse_o = (cnt == 0);
				cnt = (cnt + 1) % PER_SEC;
			end
		end
	end
endmodule

/* File: tb/playback_output_timing_tb.sv */
// Self-checking bench for the playback output timing block.
module playback_output_timing_tb import playback_timing_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [2:0] dv, rk; logic [4:0] sh; logic [31:0] d, e, q, per;} row_s;
	row_s rows [3] = '{
		'{3'h0, 3'h0, 5'h00, 32'h12345678, 32'hFFFFFFFF, 32'h12345678, 32'h8},
		'{3'h0, 3'h2, 5'h01, 32'h12345678, 32'h0000FFFF, 32'hFFFF2B3C, 32'h20},
		'{3'h1, 3'h1, 5'h1F, 32'h12345678, 32'hFFFF0000, 32'h2468FFFF, 32'h20}};
	logic         clk = 0, resetn = 0, run = 1, arm = 0, sval = 0;
	logic         ref_clk, epoch, sready, rtick, otick, sstb, oval, aux, mon, armed, fault;
	logic [7:0]   sbyte = 8'h00;
	logic [8:0]   b;
	logic [31:0]  secs = 32'h100, sdata = 32'h0, en = 32'h0, strm, osecs, n;
	logic [159:0] smap = 160'h0;
	logic [23:0]  incr = 24'h010000;
	logic [2:0]   dv = 3'h0, rk = 3'h0;
	logic         dval = 1'b1;
	logic [15:0]  dly = 16'h0000;
	int           error_cnt = 0, n_checks = 0;

	always #2 clk = ~clk;
	proc_sys_model ps (.run_i(run), .ref_clock_o(ref_clk), .epoch_pulse_o(epoch));
	playback_output_timing #(.MON_CYCLES(20), .SERIAL_DIV(4), .SERIAL_BURST(3)) dut (
		.clk_sys_i(clk), .resetn_i(resetn), .ref_clock_in_i(ref_clk),
		.epoch_pulse_in_i(epoch), .epoch_arm_i(arm), .epoch_seconds_i(secs),
		.ref_freq_hz_i(28'h8), .observe_incr_i(incr), .out_div_log2_i(dv), .rate_k_i(rk),
		.delay_offset_i(dly), .stream_data_i(sdata), .stream_map_i(smap),
		.stream_enable_i(en), .data_valid_i(dval), .serial_tick_sel_i(1'b0),
		.serial_valid_i(sval), .serial_byte_i(sbyte), .serial_ready_o(sready),
		.recon_clock_o(), .recon_tick_out_o(rtick), .observe_time_tick_out_o(otick),
		.recon_stream_out_o(strm), .sample_strobe_o(sstb), .output_valid_o(oval),
		.aux_serial_out_o(aux), .observe_tick_monitor_o(mon), .observe_seconds_o(osecs),
		.epoch_armed_o(armed), .ref_fault_o(fault));

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Counts falling edges up to the next rise of the tick or of the sample strobe.
	task automatic wait_rise(input bit s, output logic [31:0] k);
		k = 0;
		while ((s ? sstb : rtick) && k < 3000) begin @(negedge clk); k++; end
		while (!(s ? sstb : rtick) && k < 3000) begin @(negedge clk); k++; end
	endtask

	// Samples one character near the middle of each bit, stop bit last.
	task automatic rx(output logic [8:0] v);
		int i;
		i = 0;
		while (aux && i < 400) begin @(negedge clk); i++; end
		repeat (2) @(negedge clk);
		for (i = 0; i < 9; i++) begin repeat (4) @(negedge clk); v[i] = aux; end
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		summarize();
	end

	initial begin
		repeat (5) @(negedge clk);
		resetn = 1;
		repeat (40) @(negedge clk);
		check(armed, 0); check(osecs, 0); check(oval, 0);
		arm = 1;
		@(negedge clk) arm = 0;
		@(negedge clk) check(armed, 1);
		n = 0;
		while (armed && n < 300) begin @(negedge clk); n++; end
		check(osecs, 32'h100);
		repeat (4) wait_rise(0, n);
		check(osecs, 32'h103); check(n, 64); check(oval, 1);
		dval = 1'b0;
		repeat (2) @(negedge clk);
		check(oval, 0);
		dval = 1'b1;
		incr = 24'h020000;
		repeat (3) wait_rise(0, n);
		check(n, 32);
		incr = 24'h010000;
		wait_rise(0, n);
		$display("epoch and tick test done");
		foreach (rows[r]) begin
			dv = rows[r].dv; rk = rows[r].rk; sdata = rows[r].d; en = rows[r].e;
			for (int j = 0; j < 32; j++) smap[5*j +: 5] = 5'(j + rows[r].sh);
			repeat (3) wait_rise(1, n);
			check(n, rows[r].per);
			check(strm, rows[r].q);
			$display("stream row %0d done", r);
		end
		dv = 3'h0; rk = 3'h0; incr = 24'h001000;
		repeat (3) wait_rise(0, n);
		check(n, 1024);
		fork
			begin
				sval = 1;
				for (int j = 0; j < 3; j++) begin
					sbyte = 8'hA5 + 8'(j);
					while (!sready) @(negedge clk);
					@(negedge clk);
				end
				sval = 0;
			end
			for (int j = 0; j < 3; j++) begin
				rx(b);
				check(32'(b), 32'({1'b1, 8'hA5 + 8'(j)}));
			end
		join
		repeat (4) @(negedge clk);
		check(sready, 0);
		wait_rise(0, n);
		@(negedge clk) check(sready, 1);
		$display("serial test done");
		run = 0;
		n = 0;
		while (!fault && n < 400) begin @(negedge clk); n++; end
		check(fault, 1);
		@(negedge clk) check(oval, 0);
		resetn = 0;
		repeat (2) @(negedge clk);
		check(strm, 32'hFFFFFFFF); check(aux, 1); check(fault, 0);
		$display("fault and reset test done");
		summarize();
	end
endmodule
